// ### hdl/bfp_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the breaker failure timer
// Assumes: 20 MHz aclk, one evaluation tick every 5 ms
// Notes: delay registers hold whole 5 ms steps, one step per evaluation tick
`ifndef BFP_MAP_SVH
`define BFP_MAP_SVH
// ==========================================
// timing
`define BFP_CLK_HZ 20000000
`define BFP_TICK_MS 5
`define BFP_TICK_CYCLES (`BFP_TICK_MS * `BFP_CLK_HZ / 1000)
`define BFP_REL_NUM 97
`define BFP_REL_DEN 100
// ==========================================
// register offsets
`define BFP_OFF_CTRL 8'h00
`define BFP_OFF_PH_THR 8'h04
`define BFP_OFF_RES_THR 8'h08
`define BFP_OFF_RETRIP_DLY 8'h0c
`define BFP_OFF_FAIL_DLY 8'h10
`define BFP_OFF_STATUS 8'h14
`define BFP_OFF_ELAPSED 8'h18
// ==========================================
// fields and reset values
`define BFP_CTRL_RETRIP_EN 0
`define BFP_CTRL_CRIT_LO 1
`define BFP_CTRL_RES_LO 3
`define BFP_CTRL_RST 5'h01
`define BFP_PH_THR_RST 16'h0014
`define BFP_RES_THR_RST 16'h04b0
`define BFP_RETRIP_DLY_RST 19'h00014
`define BFP_FAIL_DLY_RST 19'h00028
`define BFP_RESP_OKAY 2'h0
`define BFP_RESP_SLVERR 2'h2
`endif

// ### hdl/bfp_pin_filter.sv
// Purpose: three-flop synchroniser with agreement filter for a pin level
// Assumes: input asynchronous to aclk
// Notes: level follows only when the second and third flops agree
module bfp_pin_filter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   // ==========================================
   // synchroniser; s1 is read by s2 only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   // ==========================================
   // agreement filter keeps a one-flop glitch out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         level <= s3_ff;
      end
   end
endmodule

// ### hdl/bfp_pkg.sv
// Purpose: types shared by the breaker failure timer
// Assumes: nothing
// Notes: enum order is the register encoding
package bfp_pkg;
   typedef enum logic [2:0] {
      BFP_NORMAL,
      BFP_STARTED,
      BFP_RETRIP,
      BFP_FAILED,
      BFP_BLOCKED
   } bfp_cond_e;
   typedef enum logic [1:0] {
      BFP_CUR_ONLY,
      BFP_CUR_AND_TRIP,
      BFP_CUR_OR_TRIP
   } bfp_crit_e;
   typedef enum logic [1:0] {
      BFP_RES_NONE,
      BFP_RES_FIRST,
      BFP_RES_SECOND,
      BFP_RES_CALC
   } bfp_res_src_e;
endpackage

// ### hdl/bfp_top.sv
// Purpose: breaker failure protection timing, retrip and failure outputs, AXI4-Lite settings
// Assumes: current magnitudes arrive on aclk; block and primary trip are pins
// Notes: all decisions are taken once per evaluation tick
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`include "bfp_map.svh"
module bfp_top import bfp_pkg::*; #(
   parameter int TICK_CYCLES = `BFP_TICK_CYCLES,
   parameter int DW = 16,
   parameter int TW = 19
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [DW-1:0] phase_a_current,
   input wire logic [DW-1:0] phase_b_current,
   input wire logic [DW-1:0] phase_c_current,
   input wire logic [DW-1:0] first_residual_input,
   input wire logic [DW-1:0] second_residual_input,
   input wire logic [DW-1:0] calculated_residual,
   input wire logic block_pin,
   input wire logic primary_trip_pin,
   output logic start_out,
   output logic redundant_coil_trip,
   output logic breaker_fail_output,
   output logic blocked_out,
   output logic [2:0] function_condition
);
   localparam int TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
   localparam int MW = DW + 7;
   localparam logic [MW-1:0] REL_NUM = MW'(`BFP_REL_NUM);
   localparam logic [MW-1:0] REL_DEN = MW'(`BFP_REL_DEN);

   // settings
   logic [4:0] ctrl_ff;
   logic [DW-1:0] ph_thr_ff;
   logic [DW-1:0] res_thr_ff;
   logic [TW-1:0] retrip_dly_ff;
   logic [TW-1:0] fail_dly_ff;
   logic retrip_en;
   bfp_crit_e crit;
   bfp_res_src_e res_src;
   // timing state
   logic [TCW-1:0] tick_cnt_ff;
   logic tick;
   logic block_s;
   logic trip_s;
   logic ph_pick_ff;
   logic res_pick_ff;
   logic nxt_ph_pick;
   logic nxt_res_pick;
   logic cur_pick;
   logic start_cond;
   logic run;
   logic blk_ind;
   logic [TW-1:0] cnt_ff;
   logic [TW-1:0] nxt_cnt;
   logic nxt_retrip;
   logic nxt_fail;
   bfp_cond_e nxt_cond;
   logic [DW-1:0] res_val;
   // bus state
   logic aw_got_ff;
   logic w_got_ff;
   logic [7:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_go;
   logic [31:0] wr_old;
   logic [31:0] wr_new;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;

   assign retrip_en = ctrl_ff[`BFP_CTRL_RETRIP_EN];
   assign crit = bfp_crit_e'(ctrl_ff[`BFP_CTRL_CRIT_LO +: 2]);
   assign res_src = bfp_res_src_e'(ctrl_ff[`BFP_CTRL_RES_LO +: 2]);

   // ==========================================
   // pin inputs
   bfp_pin_filter u_block_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(block_pin),
      .level(block_s)
   );
   bfp_pin_filter u_trip_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(primary_trip_pin),
      .level(trip_s)
   );

   // ==========================================
   // evaluation tick, one every 5 ms
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + TCW'(1);
      end
   end
   assign tick = (tick_cnt_ff == TICK_LAST);

   // ==========================================
   // current pick-up with 97 percent release
   function automatic logic over(input logic [DW-1:0] i, input logic [DW-1:0] thr);
      over = i > thr;
   endfunction
   function automatic logic released(input logic [DW-1:0] i, input logic [DW-1:0] thr);
      released = (MW'(i) * REL_DEN) < (MW'(thr) * REL_NUM);
   endfunction

   always_comb begin
      case (res_src)
         BFP_RES_FIRST: res_val = first_residual_input;
         BFP_RES_SECOND: res_val = second_residual_input;
         BFP_RES_CALC: res_val = calculated_residual;
         default: res_val = '0;
      endcase
   end

   always_comb begin
      if (ph_pick_ff) begin
         nxt_ph_pick = !(released(phase_a_current, ph_thr_ff) && released(phase_b_current, ph_thr_ff) &&
                         released(phase_c_current, ph_thr_ff));
      end else begin
         nxt_ph_pick = over(phase_a_current, ph_thr_ff) || over(phase_b_current, ph_thr_ff) ||
                       over(phase_c_current, ph_thr_ff);
      end
      if (res_src == BFP_RES_NONE) begin
         nxt_res_pick = 1'b0;
      end else if (res_pick_ff) begin
         nxt_res_pick = !released(res_val, res_thr_ff);
      end else begin
         nxt_res_pick = over(res_val, res_thr_ff);
      end
   end
   assign cur_pick = nxt_ph_pick || nxt_res_pick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_pick_ff <= 1'b0;
         res_pick_ff <= 1'b0;
      end else if (tick) begin
         ph_pick_ff <= nxt_ph_pick;
         res_pick_ff <= nxt_res_pick;
      end
   end

   // ==========================================
   // start criterion and blocking
   always_comb begin
      case (crit)
         BFP_CUR_AND_TRIP: start_cond = cur_pick && trip_s;
         BFP_CUR_OR_TRIP: start_cond = cur_pick || trip_s;
         default: start_cond = cur_pick;
      endcase
   end
   // block is read at the tick itself, before the counter step
   assign run = start_cond && !block_s;
   assign blk_ind = start_cond && block_s;

   // ==========================================
   // shared delay counter, saturating so a long start never wraps
   always_comb begin
      if (!run) begin
         nxt_cnt = '0;
      end else if (cnt_ff == '1) begin
         nxt_cnt = cnt_ff;
      end else begin
         nxt_cnt = cnt_ff + TW'(1);
      end
      nxt_retrip = run && retrip_en && (nxt_cnt >= retrip_dly_ff);
      nxt_fail = run && (nxt_cnt >= fail_dly_ff);
      if (blk_ind) begin
         nxt_cond = BFP_BLOCKED;
      end else if (nxt_fail) begin
         nxt_cond = BFP_FAILED;
      end else if (nxt_retrip) begin
         nxt_cond = BFP_RETRIP;
      end else if (run) begin
         nxt_cond = BFP_STARTED;
      end else begin
         nxt_cond = BFP_NORMAL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
         start_out <= 1'b0;
         blocked_out <= 1'b0;
         redundant_coil_trip <= 1'b0;
         breaker_fail_output <= 1'b0;
         function_condition <= BFP_NORMAL;
      end else if (tick) begin
         cnt_ff <= nxt_cnt;
         start_out <= run;
         blocked_out <= blk_ind;
         redundant_coil_trip <= nxt_retrip;
         breaker_fail_output <= nxt_fail;
         function_condition <= nxt_cond;
      end
   end

   // ==========================================
   // axi4-lite write channel
   assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
   assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         waddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BFP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `BFP_RESP_OKAY : `BFP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      case ({waddr_ff[7:2], 2'b00})
         `BFP_OFF_CTRL: wr_old = {27'h0, ctrl_ff};
         `BFP_OFF_PH_THR: wr_old = 32'(ph_thr_ff);
         `BFP_OFF_RES_THR: wr_old = 32'(res_thr_ff);
         `BFP_OFF_RETRIP_DLY: wr_old = 32'(retrip_dly_ff);
         `BFP_OFF_FAIL_DLY: wr_old = 32'(fail_dly_ff);
         default: begin
            wr_old = 32'h0000_0000;
            wr_hit = 1'b0;
         end
      endcase
      for (int b = 0; b < 4; b++) begin
         wr_new[8*b +: 8] = wstrb_ff[b] ? wdata_ff[8*b +: 8] : wr_old[8*b +: 8];
      end
   end

   // settings are taken by the counter at the next tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `BFP_CTRL_RST;
         ph_thr_ff <= `BFP_PH_THR_RST;
         res_thr_ff <= `BFP_RES_THR_RST;
         retrip_dly_ff <= `BFP_RETRIP_DLY_RST;
         fail_dly_ff <= `BFP_FAIL_DLY_RST;
      end else if (wr_go) begin
         case ({waddr_ff[7:2], 2'b00})
            `BFP_OFF_CTRL: ctrl_ff <= wr_new[4:0];
            `BFP_OFF_PH_THR: ph_thr_ff <= wr_new[DW-1:0];
            `BFP_OFF_RES_THR: res_thr_ff <= wr_new[DW-1:0];
            `BFP_OFF_RETRIP_DLY: retrip_dly_ff <= wr_new[TW-1:0];
            `BFP_OFF_FAIL_DLY: fail_dly_ff <= wr_new[TW-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // axi4-lite read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         `BFP_OFF_CTRL: rd_word = {27'h0, ctrl_ff};
         `BFP_OFF_PH_THR: rd_word = 32'(ph_thr_ff);
         `BFP_OFF_RES_THR: rd_word = 32'(res_thr_ff);
         `BFP_OFF_RETRIP_DLY: rd_word = 32'(retrip_dly_ff);
         `BFP_OFF_FAIL_DLY: rd_word = 32'(fail_dly_ff);
         `BFP_OFF_STATUS: rd_word = {23'h0, trip_s, ph_pick_ff | res_pick_ff, blocked_out, breaker_fail_output,
                                     redundant_coil_trip, start_out, function_condition};
         `BFP_OFF_ELAPSED: rd_word = 32'(cnt_ff);
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `BFP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? `BFP_RESP_OKAY : `BFP_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_tick_run;
      tick && run;
   endsequence
   sequence s_tick_idle;
      tick && !run;
   endsequence
   AST_BLOCK_SUPPRESS: assert property (blocked_out |-> !redundant_coil_trip && !breaker_fail_output)
      else $error("output active while blocked");
   AST_RETRIP_GATED: assert property (tick && !retrip_en |=> !redundant_coil_trip)
      else $error("retrip while disabled");
   AST_CLEAR_SAME_TICK: assert property (s_tick_idle |=>
      cnt_ff == '0 && !redundant_coil_trip && !breaker_fail_output)
      else $error("outputs outlive counter clear");
   AST_FAIL_AT_DELAY: assert property (s_tick_run ##0 (nxt_cnt >= fail_dly_ff) |=> breaker_fail_output)
      else $error("failure output late");
   AST_FAIL_NOT_EARLY: assert property (s_tick_run ##0 (nxt_cnt < fail_dly_ff) |=> !breaker_fail_output)
      else $error("failure output early");
   AST_RETRIP_AT_DELAY: assert property (s_tick_run ##0 (retrip_en && nxt_cnt >= retrip_dly_ff) |=>
      redundant_coil_trip)
      else $error("retrip late");
   AST_COUNT_STEP: assert property (s_tick_run ##0 (cnt_ff != '1) |=> cnt_ff == $past(cnt_ff) + TW'(1))
      else $error("counter did not advance one tick");
   AST_AND_HALT: assert property (tick && crit == BFP_CUR_AND_TRIP && !trip_s |=> cnt_ff == '0 && !start_out)
      else $error("counting without primary trip");
   AST_OR_TRIP_RUNS: assert property (tick && crit == BFP_CUR_OR_TRIP && trip_s && !block_s |=> start_out)
      else $error("primary trip alone did not start");
   AST_BLOCK_IND: assert property (tick && start_cond && block_s |=> blocked_out && !start_out)
      else $error("blocked indication missing");
   AST_TICK_SPACING: assert property (tick |=> !tick)
      else $error("ticks back to back");
endmodule

// ### sim/bfp_far_side.sv
// Purpose: far side of the breaker failure timer: primary trip relay and breaker coils
// Assumes: tb commands the primary trip level and whether the redundant coil works
// Notes: breaker opens OP_CYC + 1 cycles after the retrip coil is energised, only if coil_ok
module bfp_far_side #(
   parameter int OP_CYC = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic trip_cmd,
   input wire logic redundant_coil_trip,
   input wire logic coil_ok,
   input wire logic close_cmd,
   output logic primary_trip_pin,
   output logic breaker_open
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // ==========================================
   // relay and breaker
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         primary_trip_pin <= 1'h0;
         breaker_open <= 1'h0;
         cnt <= 0;
      end else begin
         primary_trip_pin <= trip_cmd;
         if (close_cmd) begin
            breaker_open <= 1'h0;
            cnt <= 0;
         end else if (redundant_coil_trip && coil_ok) begin
            // operating time kept short of the failure delay in use
            cnt <= cnt + 1;
            if (cnt >= OP_CYC) begin
               breaker_open <= 1'h1;
            end
         end
      end
   end
endmodule

// ### sim/bfp_top_tb.sv
// Purpose: self-checking bench of the breaker failure timer
// Assumes: TICK_CYCLES shortened to 8; settings written over AXI4-Lite
// Notes: inputs change at the rising edge, outputs are sampled on the falling edge
`include "bfp_map.svh"
module bfp_top_tb import bfp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 8;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] ia = 16'h0, ib = 16'h0, ic = 16'h0, r1 = 16'h0, r2 = 16'h0, rc = 16'h0;
   logic blk = 1'h0, trip_cmd = 1'h0, close_cmd = 1'h0, coil_ok = 1'h0, fail_seen = 1'h0;
   logic trip_pin, start_out, redundant_coil_trip, breaker_fail_output, blocked_out, breaker_open;
   logic [2:0] function_condition;
   int num_errors = 0;
   int check_count = 0;
   int seed = 53;
   int rd, fd, prev, i;
   int hv[7] = '{101, 98, 97, 96, 100, 101, 0};
   initial begin
      forever #25 aclk = ~aclk;
   end
   always @(negedge aclk) if (breaker_fail_output === 1'h1) fail_seen <= 1'h1;
   bfp_top #(.TICK_CYCLES(TC)) bfp_top_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .phase_a_current(ia), .phase_b_current(ib), .phase_c_current(ic),
      .first_residual_input(r1), .second_residual_input(r2), .calculated_residual(rc),
      .block_pin(blk), .primary_trip_pin(trip_pin), .start_out(start_out),
      .redundant_coil_trip(redundant_coil_trip), .breaker_fail_output(breaker_fail_output),
      .blocked_out(blocked_out), .function_condition(function_condition));
   bfp_far_side #(.OP_CYC(2 * TC)) bfp_far_side_inst (.aclk(aclk), .aresetn(aresetn),
      .trip_cmd(trip_cmd), .redundant_coil_trip(redundant_coil_trip), .coil_ok(coil_ok),
      .close_cmd(close_cmd), .primary_trip_pin(trip_pin), .breaker_open(breaker_open));
   // ==========================================
   // checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic fail_to(input string what);
      num_errors++;
      $display("MISMATCH t=%0t timeout %s", $time, what);
      wrap_up();
   endtask
   function automatic bfp_cond_e exp_cond(input logic b, input logic f, input logic r, input logic s);
      if (b) return BFP_BLOCKED;
      if (f) return BFP_FAILED;
      if (r) return BFP_RETRIP;
      if (s) return BFP_STARTED;
      return BFP_NORMAL;
   endfunction
   // pick-up level with release below 97 percent of threshold
   function automatic int exp_pick(input int p, input int cur, input int thr);
      if (cur > thr) return 1;
      if (cur * 100 < thr * 97) return 0;
      return p;
   endfunction
   task automatic chk_outs(input logic s, input logic r, input logic f, input logic b);
      chk(32'(start_out), 32'(s), "start");
      chk(32'(redundant_coil_trip), 32'(r), "retrip");
      chk(32'(breaker_fail_output), 32'(f), "fail");
      chk(32'(blocked_out), 32'(b), "blocked");
      chk(32'(function_condition), 32'(exp_cond(b, f, r, s)), "condition");
   endtask
   // ==========================================
   // AXI4-Lite master
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         if (tb) chk(32'(bresp), 32'(er), "bresp");
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tb) begin
            bready <= 1'h0;
            break;
         end
      end
      if (k == 50) fail_to("write");
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr;
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         if (tr) chk(rdata, ed, "rdata");
         if (tr) chk(32'(rresp), 32'(er), "rresp");
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
         if (tr) begin
            rready <= 1'h0;
            break;
         end
      end
      if (k == 50) fail_to("read");
   endtask
   task automatic cfg(input int crit, input int en, input int src, input int r, input int f);
      axi_wr(`BFP_OFF_CTRL, 32'((src << 3) | (crit << 1) | en), `BFP_RESP_OKAY);
      axi_wr(`BFP_OFF_RETRIP_DLY, 32'(r), `BFP_RESP_OKAY);
      axi_wr(`BFP_OFF_FAIL_DLY, 32'(f), `BFP_RESP_OKAY);
   endtask
   // ==========================================
   // waits
   task automatic wait_on(input int which, input logic v, output int cyc);
      logic s;
      for (cyc = 0; cyc < 3000; cyc++) begin
         @(negedge aclk);
         case (which)
            0: s = start_out;
            1: s = redundant_coil_trip;
            2: s = breaker_fail_output;
            3: s = blocked_out;
            default: s = breaker_open;
         endcase
         if (s === v) return;
      end
      fail_to("wait");
   endtask
   task automatic lat(input int which, input int exp);
      int c;
      wait_on(which, 1'h1, c);
      chk(32'(c + 1), 32'(exp), "latency");
   endtask
   task automatic settle(input int t);
      repeat (t * TC + 6) @(negedge aclk);
   endtask
   task automatic drop_all();
      int c;
      @(posedge aclk) ia <= 16'h0;
      @(posedge aclk) ib <= 16'h0;
      @(posedge aclk) ic <= 16'h0;
      wait_on(0, 1'h0, c);
      settle(1);
      chk_outs(1'h0, 1'h0, 1'h0, 1'h0);
   endtask
   // ==========================================
   // main sequence
   initial begin
      int c;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(`BFP_OFF_CTRL, 32'(`BFP_CTRL_RST), `BFP_RESP_OKAY);
      axi_rd(`BFP_OFF_PH_THR, 32'(`BFP_PH_THR_RST), `BFP_RESP_OKAY);
      axi_rd(`BFP_OFF_RES_THR, 32'(`BFP_RES_THR_RST), `BFP_RESP_OKAY);
      axi_rd(`BFP_OFF_RETRIP_DLY, 32'(`BFP_RETRIP_DLY_RST), `BFP_RESP_OKAY);
      axi_rd(`BFP_OFF_FAIL_DLY, 32'(`BFP_FAIL_DLY_RST), `BFP_RESP_OKAY);
      axi_wr(`BFP_OFF_STATUS, 32'h7, `BFP_RESP_SLVERR);
      axi_rd(`BFP_OFF_STATUS, 32'h0, `BFP_RESP_OKAY);
      axi_wr(8'h1c, 32'h1, `BFP_RESP_SLVERR);
      axi_rd(8'h1c, 32'h0, `BFP_RESP_SLVERR);
      // defaults, current only, primary trip held but ignored
      @(posedge aclk) trip_cmd <= 1'h1;
      @(posedge aclk) ia <= 16'h0015;
      wait_on(0, 1'h1, c);
      chk_outs(1'h1, 1'h0, 1'h0, 1'h0);
      lat(1, (`BFP_RETRIP_DLY_RST - 1) * TC);
      chk_outs(1'h1, 1'h1, 1'h0, 1'h0);
      lat(2, (`BFP_FAIL_DLY_RST - `BFP_RETRIP_DLY_RST) * TC);
      chk_outs(1'h1, 1'h1, 1'h1, 1'h0);
      drop_all();
      @(posedge aclk) trip_cmd <= 1'h0;
      // random delays and phases, last pass with retrip disabled
      for (i = 0; i < 3; i++) begin
         rd = 2 + ($random(seed) & 3);
         fd = rd + 2 + ($random(seed) & 3);
         cfg(0, (i < 2) ? 1 : 0, 0, rd, fd);
         if (i == 1) @(posedge aclk) ib <= 16'h0015 + 16'($random(seed) & 63);
         else @(posedge aclk) ic <= 16'h0015 + 16'($random(seed) & 63);
         wait_on(0, 1'h1, c);
         if (i < 2) begin
            lat(1, (rd - 1) * TC);
            lat(2, (fd - rd) * TC);
         end else begin
            lat(2, (fd - 1) * TC);
         end
         chk_outs(1'h1, (i < 2) ? 1'h1 : 1'h0, 1'h1, 1'h0);
         drop_all();
      end
      // current and trip
      cfg(1, 1, 0, 3, 6);
      @(posedge aclk) ia <= 16'h0100;
      settle(4);
      chk_outs(1'h0, 1'h0, 1'h0, 1'h0);
      @(posedge aclk) trip_cmd <= 1'h1;
      wait_on(0, 1'h1, c);
      lat(1, 2 * TC);
      @(posedge aclk) trip_cmd <= 1'h0;
      wait_on(0, 1'h0, c);
      chk_outs(1'h0, 1'h0, 1'h0, 1'h0);
      drop_all();
      // current or trip
      cfg(2, 1, 0, 3, 6);
      @(posedge aclk) trip_cmd <= 1'h1;
      wait_on(0, 1'h1, c);
      lat(1, 2 * TC);
      @(posedge aclk) ia <= 16'h0100;
      @(posedge aclk) trip_cmd <= 1'h0;
      settle(2);
      chk(32'(start_out), 32'h1, "or hold");
      drop_all();
      // criterion code 3 falls back to current only, so a lone primary trip starts nothing
      cfg(3, 1, 0, 3, 6);
      @(posedge aclk) trip_cmd <= 1'h1;
      settle(2);
      chk(32'(start_out), 32'h0, "code 3");
      @(posedge aclk) trip_cmd <= 1'h0;
      // blocking before and during start; block raised well ahead of expiry
      cfg(0, 1, 0, 3, 6);
      @(posedge aclk) blk <= 1'h1;
      settle(2);
      @(posedge aclk) ia <= 16'h0100;
      wait_on(3, 1'h1, c);
      settle(7);
      chk_outs(1'h0, 1'h0, 1'h0, 1'h1);
      @(posedge aclk) blk <= 1'h0;
      wait_on(0, 1'h1, c);
      lat(1, 2 * TC);
      @(posedge aclk) blk <= 1'h1;
      wait_on(3, 1'h1, c);
      chk_outs(1'h0, 1'h0, 1'h0, 1'h1);
      @(posedge aclk) blk <= 1'h0;
      wait_on(0, 1'h1, c);
      lat(1, 2 * TC);
      drop_all();
      // retrip clears the fault before the failure delay
      cfg(0, 1, 0, 3, 8);
      fail_seen = 1'h0;
      @(posedge aclk) coil_ok <= 1'h1;
      @(posedge aclk) ia <= 16'h0100;
      wait_on(4, 1'h1, c);
      drop_all();
      chk(32'(fail_seen), 32'h0, "no failure");
      @(posedge aclk) close_cmd <= 1'h1;
      @(posedge aclk) close_cmd <= 1'h0;
      // hysteresis at a threshold of 100
      axi_wr(`BFP_OFF_PH_THR, 32'h64, `BFP_RESP_OKAY);
      cfg(0, 1, 0, 300, 400);
      prev = 0;
      for (i = 0; i < 7; i++) begin
         @(posedge aclk) ib <= 16'(hv[i]);
         settle(2);
         prev = exp_pick(prev, hv[i], 100);
         chk(32'(start_out), 32'(prev), "hysteresis");
      end
      // residual sources, none never picks
      for (i = 3; i >= 0; i--) begin
         cfg(0, 1, i, 300, 400);
         @(posedge aclk) r1 <= (i == 1 || i == 0) ? 16'h04b1 : 16'h0;
         @(posedge aclk) r2 <= (i == 2 || i == 0) ? 16'h04b1 : 16'h0;
         @(posedge aclk) rc <= (i == 3 || i == 0) ? 16'h04b1 : 16'h0;
         settle(2);
         chk(32'(start_out), 32'(i != 0), "residual");
         @(posedge aclk) r1 <= 16'h0;
         @(posedge aclk) r2 <= 16'h0;
         @(posedge aclk) rc <= 16'h0;
         settle(2);
         chk(32'(start_out), 32'h0, "residual off");
      end
      wrap_up();
   end
endmodule
